/* File: rtl/watchdog_timer.sv */
// watchdog timer with fuse safety level and timed unlock, avalon slave
`timescale 1ns/10ps

module watchdog_timer #(
  parameter int unsigned PERIOD_UNIT = watchdog_pkg::BASE_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_power_on,
  // fuse pin, high when programmed
  input wire logic i_always_on_fuse,
  // avalon-mm slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic o_waitrequest,
  output logic [31:0] o_readdata,
  // chip reset request
  output logic o_chip_reset
);

  watchdog_pkg::wdt_state_type st_r;
  watchdog_pkg::wdt_state_type st_nxt;

  function automatic logic [31:0] period_of(input logic [2:0] sel);
    period_of = 32'(PERIOD_UNIT) << sel;
  endfunction : period_of

  function automatic logic [31:0] ctl_view(
    input watchdog_pkg::wdt_state_type s
  );
    logic [31:0] v;
    v = 32'h0;
    v[watchdog_pkg::CTL_UNLOCK_BIT] = (s.unlock_cnt != 3'h0);
    v[watchdog_pkg::CTL_ENABLE_BIT] = s.enable | s.level2;
    v[watchdog_pkg::CTL_SEL_LSB +: watchdog_pkg::CTL_SEL_W] = s.sel;
    ctl_view = v;
  endfunction : ctl_view

  logic access;
  logic wr_go;
  logic wr_unlock;
  logic wr_enable;
  logic [2:0] wr_sel;
  logic tick;
  logic restart;
  logic timeout;
  logic active;

  always_comb begin
    st_nxt = st_r;
    access = (i_read | i_write) & st_r.waitrequest;
    // a write lands only on the edge that sees waitrequest low
    wr_go = i_write & ~st_r.waitrequest;
    wr_unlock = i_writedata[watchdog_pkg::CTL_UNLOCK_BIT];
    wr_enable = i_writedata[watchdog_pkg::CTL_ENABLE_BIT];
    wr_sel = i_writedata[watchdog_pkg::CTL_SEL_LSB +:
                         watchdog_pkg::CTL_SEL_W];
    active = st_r.enable | st_r.level2;
    tick = (st_r.div_cnt == watchdog_pkg::OSC_DIV_LAST);
    // restart is a write to its own address
    restart = wr_go && (i_address == watchdog_pkg::ADDR_RESTART);
    timeout = active && tick &&
              (st_r.wdt_cnt == period_of(st_r.sel) - 32'h1);

    // fuse pin synchroniser
    st_nxt.fuse_meta = i_always_on_fuse;
    st_nxt.fuse_sync = st_r.fuse_meta;

    // oscillator divider
    st_nxt.div_cnt = tick ? 6'h0 : st_r.div_cnt + 6'h1;

    // window closes four cycles after opening
    if (st_r.unlock_cnt != 3'h0) begin
      st_nxt.unlock_cnt = st_r.unlock_cnt - 3'h1;
    end

    if (wr_go && i_address == watchdog_pkg::ADDR_CONTROL) begin
      if (wr_unlock && wr_enable) begin
        st_nxt.unlock_cnt = watchdog_pkg::UNLOCK_CYCLES;
        st_nxt.enable = 1'b1;
      end else if (!wr_unlock && st_r.unlock_cnt != 3'h0) begin
        st_nxt.sel = wr_sel;
        st_nxt.unlock_cnt = 3'h0;
        st_nxt.enable = st_r.level2 | wr_enable;
      end else if (wr_enable) begin
        st_nxt.enable = 1'b1;
      end
    end
    if (st_r.level2) begin
      st_nxt.enable = 1'b1;
    end

    if (restart || !active || timeout) begin
      st_nxt.wdt_cnt = 32'h0;
    end else if (tick) begin
      st_nxt.wdt_cnt = st_r.wdt_cnt + 32'h1;
    end

    st_nxt.chip_reset = timeout;

    // set beats a software clear in the same cycle
    if (wr_go && i_address == watchdog_pkg::ADDR_RESET_STATUS &&
        !i_writedata[watchdog_pkg::STS_CAUSE_BIT]) begin
      st_nxt.cause_flag = 1'b0;
    end
    if (timeout) begin
      st_nxt.cause_flag = 1'b1;
    end

    // one wait cycle, then answer for one cycle
    st_nxt.waitrequest = ~access;
    if (access) begin
      case (i_address)
        watchdog_pkg::ADDR_CONTROL: st_nxt.readdata = ctl_view(st_r);
        watchdog_pkg::ADDR_RESET_STATUS: begin
          st_nxt.readdata = 32'h0;
          st_nxt.readdata[watchdog_pkg::STS_CAUSE_BIT] = st_r.cause_flag;
        end
        watchdog_pkg::ADDR_COUNT: st_nxt.readdata = st_r.wdt_cnt;
        default: st_nxt.readdata = 32'h0;
      endcase
    end

    if (i_reset) begin
      // level and initial enable follow the fuse
      st_nxt.level2 = st_r.fuse_sync;
      st_nxt.enable = st_r.fuse_sync;
      st_nxt.sel = watchdog_pkg::SEL_RESET;
      st_nxt.unlock_cnt = 3'h0;
      st_nxt.div_cnt = 6'h0;
      // any chip reset clears the counter
      st_nxt.wdt_cnt = 32'h0;
      st_nxt.chip_reset = 1'b0;
      st_nxt.waitrequest = 1'b1;
      st_nxt.readdata = 32'h0;
      if (i_power_on) begin
        st_nxt.cause_flag = 1'b0;
      end
    end
  end

  // single clock: oscillator is a tick, so no crossing
  always_ff @(posedge i_sys_clk) begin
    st_r <= st_nxt;
  end

  assign o_waitrequest = st_r.waitrequest;
  assign o_readdata = st_r.readdata;
  assign o_chip_reset = st_r.chip_reset;

endmodule : watchdog_timer

/* File: rtl/watchdog_pkg.sv */
// constants and state types for the watchdog timer
package watchdog_pkg;

  // system clock and watchdog oscillator rate
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned WDT_OSC_HZ = 1_000_000;
  localparam int unsigned OSC_DIV = SYS_CLK_HZ / WDT_OSC_HZ;
  localparam logic [5:0] OSC_DIV_LAST = 6'(OSC_DIV - 1);

  // shortest period in oscillator cycles, code 000
  localparam int unsigned BASE_PERIOD_CYCLES = 16384;

  // unlock window length in system clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // avalon byte addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_RESET_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RESTART = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hc;

  // control register fields
  localparam int unsigned CTL_UNLOCK_BIT = 4;
  localparam int unsigned CTL_ENABLE_BIT = 3;
  localparam int unsigned CTL_SEL_LSB = 0;
  localparam int unsigned CTL_SEL_W = 3;
  localparam logic [2:0] SEL_RESET = 3'h0;

  // reset status register field
  localparam int unsigned STS_CAUSE_BIT = 3;

  typedef struct packed {
    logic fuse_meta;
    logic fuse_sync;
    logic level2;
    logic enable;
    logic [2:0] sel;
    logic [2:0] unlock_cnt;
    logic [5:0] div_cnt;
    logic [31:0] wdt_cnt;
    logic cause_flag;
    logic chip_reset;
    logic waitrequest;
    logic [31:0] readdata;
  } wdt_state_type;

endpackage : watchdog_pkg

/* File: tb/watchdog_timer_asserts.sv */
// bus and reset pulse checker for the watchdog
`timescale 1ns/10ps
module watchdog_timer_asserts #(
  parameter int unsigned PERIOD_UNIT = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_always_on_fuse,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic [31:0] o_readdata,
  input wire logic o_chip_reset
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic rd_ctl;
  assign rd_ctl = i_read && !o_waitrequest && i_address == 4'h0;
  chk_pulse_once: assert property (
    o_chip_reset |=> !o_chip_reset [*8]) else $error("reset pulse too long");
  chk_restart_quiet: assert property (
    i_write && !o_waitrequest && i_address == watchdog_pkg::ADDR_RESTART
    |-> ##2 !o_chip_reset [*8]) else $error("time-out after restart");
  chk_wait_one: assert property (
    $rose(i_read || i_write) |-> o_waitrequest ##1 !o_waitrequest)
    else $error("answer not after one wait");
  chk_wait_stand: assert property (
    !o_waitrequest |=> o_waitrequest) else $error("answer held too long");
  chk_level2_one: assert property (
    rd_ctl && i_always_on_fuse |-> o_readdata[3]) else $error("enable low");
  chk_reserved_zero: assert property (
    rd_ctl |-> o_readdata[31:5] == 27'h0) else $error("reserved bits set");
  chk_unmapped_zero: assert property (
    i_read && !o_waitrequest && i_address[1:0] != 2'h0 |-> o_readdata == 0)
    else $error("unmapped read not zero");
  chk_data_stands: assert property (
    o_waitrequest |-> $stable(o_readdata)) else $error("read data moved");
  cover property (o_chip_reset);
  cover property (rd_ctl && i_always_on_fuse);
  cover property (i_write && !o_waitrequest && i_address == 4'h8);
endmodule : watchdog_timer_asserts
bind watchdog_timer watchdog_timer_asserts #(.PERIOD_UNIT(PERIOD_UNIT)) u_chk (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_always_on_fuse(i_always_on_fuse),
  .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .o_waitrequest(o_waitrequest), .o_readdata(o_readdata),
  .o_chip_reset(o_chip_reset));

/* File: tb/tb.sv */
// self-checking bench for the watchdog timer
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
module tb;
  logic i_sys_clk = 0, i_reset = 1, i_power_on = 1, i_always_on_fuse = 0;
  logic i_read = 0, i_write = 0, o_waitrequest, o_chip_reset;
  logic [3:0] i_address = 4'h0;
  logic [31:0] i_writedata = 32'h0, o_readdata, q;
  logic [2:0] s;
  int errors = 0, tests_run = 0, n;
  always #12.5 i_sys_clk = ~i_sys_clk;
  watchdog_timer #(.PERIOD_UNIT(4)) dut (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_power_on(i_power_on),
    .i_always_on_fuse(i_always_on_fuse), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_waitrequest(o_waitrequest), .o_readdata(o_readdata),
    .o_chip_reset(o_chip_reset));
  function automatic logic [31:0] ctl(input logic e, input logic [2:0] v);
    return {27'h0, 1'b0, e, v};
  endfunction : ctl
  // edges from restart to pulse, one tick of phase slack
  function automatic int tmo(input int v);
    return (4 << v) * 40;
  endfunction : tmo
  task automatic end_of_test;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic hold);
    int k;
    i_write <= w; i_read <= !w; i_address <= a; i_writedata <= d;
    k = 0;
    do begin @(posedge i_sys_clk); k++; end
    while (o_waitrequest !== 1'b0 && k < 20);
    q = o_readdata;
    if (o_waitrequest !== 1'b0) begin
      errors++; $display("ERROR %0t bus timeout", $time); end_of_test();
    end
    // hold keeps the strobe up so the next write follows at once
    if (!hold) begin i_read <= 0; i_write <= 0; @(posedge i_sys_clk); end
  endtask : bus
  task automatic rst(input logic f);
    i_reset <= 1; i_power_on <= 1; i_always_on_fuse <= f;
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 0; i_power_on <= 0;
    @(posedge i_sys_clk);
  endtask : rst
  initial begin
    n = $urandom(32'hd9ee2f4a);
    s = 3'($urandom);
    rst(1'b0);
    bus(0, 4'h0, 0, 0); `CHK(q, ctl(0, 0))
    bus(0, 4'h6, 0, 0); `CHK(q, 32'h0)
    bus(1, 4'h0, ctl(0, s | 3'h1), 0); bus(0, 4'h0, 0, 0);
    `CHK(q, ctl(0, 0))
    bus(1, 4'h0, 32'h8, 0); bus(1, 4'h0, 32'h0, 0); bus(0, 4'h0, 0, 0);
    `CHK(q, ctl(1, 0))
    bus(1, 4'h0, 32'h18, 0); repeat (6) @(posedge i_sys_clk);
    bus(1, 4'h0, ctl(1, s | 3'h1), 0); bus(0, 4'h0, 0, 0);
    `CHK(q, ctl(1, 0))
    $display("level one locking done");
    for (int v = 0; v < 8; v++) begin
      bus(1, 4'h0, 32'h18, 1); bus(1, 4'h0, ctl(1, v[2:0]), 0);
      bus(0, 4'h0, 0, 0); `CHK(q, ctl(1, v[2:0]))
      bus(1, 4'h8, $urandom, 0);
      n = 0;
      while (o_chip_reset !== 1'b1 && n < tmo(v) + 3) begin
        @(posedge i_sys_clk); n++;
      end
      `CHK(n > tmo(v) - 42 && n <= tmo(v) + 2, 1'b1)
      if (o_chip_reset !== 1'b1) end_of_test();
      bus(0, 4'h4, 0, 0); `CHK(q[3], 1'b1)
      bus(1, 4'h4, 0, 0); bus(0, 4'h4, 0, 0); `CHK(q[3], 1'b0)
    end
    $display("time-out codes done");
    bus(1, 4'h0, 32'h18, 1); bus(1, 4'h0, ctl(1, 0), 0);
    n = 0;
    repeat (4) begin
      repeat (100) begin @(posedge i_sys_clk); n += int'(o_chip_reset); end
      bus(1, 4'h8, $urandom, 0);
    end
    `CHK(n, 0)
    bus(1, 4'h0, 32'h18, 1); bus(1, 4'h0, ctl(0, s), 0); bus(0, 4'h0, 0, 0);
    `CHK(q, ctl(0, s))
    bus(0, 4'h0, 0, 0); bus(0, 4'hc, 0, 0); `CHK(q, 32'h0)
    $display("restart and disable done");
    rst(1'b1);
    bus(0, 4'h0, 0, 0); `CHK(q, ctl(1, 0))
    bus(1, 4'h0, 32'h18, 1); bus(1, 4'h0, ctl(0, 3'h2), 0);
    bus(0, 4'h0, 0, 0); `CHK(q, ctl(1, 3'h2))
    bus(1, 4'h0, 0, 0); bus(0, 4'h0, 0, 0); `CHK(q, ctl(1, 3'h2))
    $display("level two done");
    end_of_test();
  end
endmodule : tb
